/* File: logic/ssic_pkg.sv */
`default_nettype none
package ssic_pkg;
	localparam int unsigned SSIC_LANES     = 4;
	localparam int unsigned SSIC_LANE_W    = 9;
	localparam int unsigned SSIC_PARITY    = 8;
	localparam int unsigned SSIC_DATA_W    = SSIC_LANES * SSIC_LANE_W;
	localparam int unsigned SSIC_ADDR_W    = 18;
	localparam int unsigned SSIC_BURST_W   = 2;
	localparam int unsigned SSIC_WB_ADDR_W = 4;
	localparam int unsigned SSIC_WB_DATA_W = 32;

	localparam logic [SSIC_WB_ADDR_W-1:0] SSIC_REG_CTRL   = 4'h0;
	localparam logic [SSIC_WB_ADDR_W-1:0] SSIC_REG_STATUS = 4'h4;
	localparam logic [SSIC_WB_ADDR_W-1:0] SSIC_REG_ADDR   = 4'h8;

	localparam int unsigned SSIC_CTRL_THIRD   = 0;
	localparam int unsigned SSIC_ST_ACTIVE    = 0;
	localparam int unsigned SSIC_ST_LINEAR    = 1;
	localparam int unsigned SSIC_ST_POS_LSB   = 2;
	localparam int unsigned SSIC_ST_LANES_LSB = 8;

	localparam logic        SSIC_CTRL_THIRD_RST = 1'b1;
	localparam logic        SSIC_STRAP_RST      = 1'b1;
	localparam logic [1:0]  SSIC_BURST_ONE      = 2'h1;
	localparam logic [3:0]  SSIC_LANES_ALL      = 4'hF;
	localparam logic [3:0]  SSIC_LANES_NONE     = 4'h0;

	typedef struct packed {
		logic       cpu_load_strobe_n;
		logic       ctrl_load_strobe_n;
		logic       burst_step_n;
		logic       all_lanes_write_n;
		logic       lane_write_gate_n;
		logic [3:0] lane_select_n;
		logic       select_primary_n;
		logic       select_second_high;
		logic       select_third_n;
	} ssic_ctrl_t;

	typedef struct packed {
		logic                      cyc;
		logic                      stb;
		logic                      we;
		logic [3:0]                sel;
		logic [SSIC_WB_ADDR_W-1:0] adr;
		logic [SSIC_WB_DATA_W-1:0] dat;
	} ssic_wb_req_t;
endpackage : ssic_pkg
`default_nettype wire

/* File: logic/ssic_capture.sv */
`timescale 1ns/1ps
`default_nettype none
module ssic_capture #(
	parameter int unsigned ADDR_W = ssic_pkg::SSIC_ADDR_W
) (
	input  wire logic                              clk_in,
	input  wire logic                              reset_n_in,
	input  wire logic                              ce_in,
	input  wire ssic_pkg::ssic_ctrl_t              pins_in,
	input  wire logic [ADDR_W-1:0]                 addr_in,
	input  wire logic [ssic_pkg::SSIC_DATA_W-1:0]  wr_data_in,
	input  wire logic                              mode_strap_in,
	output var  logic [ssic_pkg::SSIC_DATA_W-1:0]  rd_data_out,
	output var  logic                              rd_valid_out,
	input  wire ssic_pkg::ssic_wb_req_t            wb_req_in,
	output var  logic [ssic_pkg::SSIC_WB_DATA_W-1:0] wb_dat_out,
	output var  logic                              wb_ack_out
);
	import ssic_pkg::*;

	logic [SSIC_DATA_W-1:0]  mem_q [0:(1<<ADDR_W)-1];
	logic [ADDR_W-1:0]       addr_q;
	logic [SSIC_BURST_W-1:0] start_q;
	logic [SSIC_BURST_W-1:0] cnt_q;
	logic [SSIC_BURST_W-1:0] pos;
	logic                    active_q;
	logic                    linear_q;
	logic                    strap_meta_q;
	logic                    strap_sync_q;
	logic                    strap_last_q;
	logic                    third_ok;
	logic                    third_present_q;
	logic [3:0]              wr_lanes_q;
	logic [3:0]              wr_lanes_d;
	logic [SSIC_DATA_W-1:0]  wr_data_q;
	logic [ADDR_W-1:0]       cur_addr;
	logic                    cpu_load;
	logic                    ctrl_load;
	logic                    load;
	logic                    selected;
	logic                    wb_hit;
	logic [SSIC_WB_DATA_W-1:0] rd_word;

	// Processor strobe wins only while primary enable is low
	assign cpu_load  = !pins_in.cpu_load_strobe_n
		&& !pins_in.select_primary_n;
	assign ctrl_load = !pins_in.ctrl_load_strobe_n;
	assign load      = cpu_load || ctrl_load;

	// Pin-absent variant: software marks the third enable always active
	assign third_ok = !pins_in.select_third_n
		|| !third_present_q;

	// Only consulted when load is high
	assign selected = !pins_in.select_primary_n
		&& pins_in.select_second_high
		&& third_ok;

	// Burst order from strap
	assign pos = linear_q ? SSIC_BURST_W'(start_q + cnt_q)
		: (start_q ^ cnt_q);
	assign cur_addr = {addr_q[ADDR_W-1:SSIC_BURST_W], pos};

	always_comb begin
		if (!pins_in.all_lanes_write_n) begin
			wr_lanes_d = SSIC_LANES_ALL;
		end else if (!pins_in.lane_write_gate_n) begin
			wr_lanes_d = ~pins_in.lane_select_n;
		end else begin
			wr_lanes_d = SSIC_LANES_NONE;
		end
	end

	// Address and burst start capture
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			addr_q   <= '0;
			start_q  <= '0;
			active_q <= 1'b0;
		end else if (ce_in && load) begin
			if (selected) begin
				addr_q   <= addr_in;
				start_q  <= addr_in[SSIC_BURST_W-1:0];
				active_q <= 1'b1;
			end else begin
				active_q <= 1'b0;
			end
		end
	end

	// Burst counter
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cnt_q <= '0;
		end else if (ce_in) begin
			if (load) begin
				cnt_q <= '0;
			end else if (active_q && !pins_in.burst_step_n) begin
				cnt_q <= cnt_q + SSIC_BURST_ONE;
			end
		end
	end

	// Strap pin is asynchronous: three flops, change counts on agreement
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			strap_meta_q <= SSIC_STRAP_RST;
			strap_sync_q <= SSIC_STRAP_RST;
			strap_last_q <= SSIC_STRAP_RST;
		end else if (ce_in) begin
			strap_meta_q <= mode_strap_in;
			strap_sync_q <= strap_meta_q;
			strap_last_q <= strap_sync_q;
		end
	end

	// Order tracks the settled strap; moving it mid-burst scrambles order
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			linear_q <= !SSIC_STRAP_RST;
		end else if (ce_in && strap_sync_q == strap_last_q) begin
			linear_q <= !strap_last_q;
		end
	end

	// Write controls and data registered with the edge
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wr_lanes_q <= SSIC_LANES_NONE;
			wr_data_q  <= '0;
		end else if (ce_in) begin
			wr_lanes_q <= wr_lanes_d;
			wr_data_q  <= wr_data_in;
		end
	end

	// Self-timed write one edge later; unselected lanes keep contents
	always_ff @(posedge clk_in) begin
		if (ce_in && active_q) begin
			for (int i = 0; i < SSIC_LANES; i++) begin
				if (wr_lanes_q[i]) begin
					mem_q[cur_addr][i*SSIC_LANE_W +: SSIC_LANE_W] <=
						wr_data_q[i*SSIC_LANE_W +: SSIC_LANE_W];
				end
			end
		end
	end

	// Output pipeline register
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rd_data_out  <= '0;
			rd_valid_out <= 1'b0;
		end else if (ce_in) begin
			rd_valid_out <= active_q && (wr_lanes_q == SSIC_LANES_NONE);
			if (active_q) begin
				rd_data_out <= mem_q[cur_addr];
			end
		end
	end

	// Wishbone slave, one wait state, unmapped reads give zero
	assign wb_hit = wb_req_in.cyc && wb_req_in.stb && !wb_ack_out;

	always_comb begin
		rd_word = '0;
		case (wb_req_in.adr)
			SSIC_REG_CTRL: begin
				rd_word[SSIC_CTRL_THIRD] = third_present_q;
			end
			SSIC_REG_STATUS: begin
				rd_word[SSIC_ST_ACTIVE] = active_q;
				rd_word[SSIC_ST_LINEAR] = linear_q;
				rd_word[SSIC_ST_POS_LSB +: SSIC_BURST_W] = pos;
				rd_word[SSIC_ST_LANES_LSB +: SSIC_LANES] = wr_lanes_q;
			end
			SSIC_REG_ADDR: begin
				rd_word[ADDR_W-1:0] = cur_addr;
			end
			default: begin
				rd_word = '0;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wb_ack_out <= 1'b0;
			wb_dat_out <= '0;
		end else if (ce_in) begin
			wb_ack_out <= wb_hit;
			if (wb_hit && !wb_req_in.we) begin
				wb_dat_out <= rd_word;
			end
		end
	end

	// Software says whether the third enable pin exists; the write lands
	// on the acknowledge edge, where the master sees its cycle end
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			third_present_q <= SSIC_CTRL_THIRD_RST;
		end else if (ce_in && wb_req_in.cyc && wb_req_in.stb && wb_ack_out
			&& wb_req_in.we && wb_req_in.sel[0]
			&& wb_req_in.adr == SSIC_REG_CTRL) begin
			third_present_q <= wb_req_in.dat[SSIC_CTRL_THIRD];
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);

	a_load_capture: assert property (
		ce_in && load && selected |=> active_q && addr_q == $past(addr_in)
	) else $error("Selected load did not capture address");

	a_burst_start: assert property (
		ce_in && load && selected
			|=> start_q == $past(addr_in[SSIC_BURST_W-1:0])
			&& cnt_q == '0
	) else $error("Burst start not loaded from low address bits");

	a_deselect_load: assert property (
		ce_in && load && !selected |=> !active_q ##1 !rd_valid_out
	) else $error("Deselect load left the chip active");

	a_burst_step: assert property (
		ce_in && !load && active_q && !pins_in.burst_step_n
			|=> cnt_q == $past(cnt_q) + SSIC_BURST_ONE
	) else $error("Burst counter failed to advance");

	a_burst_hold: assert property (
		ce_in && !load && pins_in.burst_step_n |=> $stable(cnt_q)
	) else $error("Burst counter moved without advance");

	a_cpu_ignored: assert property (
		ce_in && !pins_in.cpu_load_strobe_n && pins_in.select_primary_n
			&& pins_in.ctrl_load_strobe_n
			|=> $stable(active_q) && $stable(addr_q)
	) else $error("Processor strobe honoured with primary enable high");

	a_enables_ignored: assert property (
		ce_in && !load && active_q |=> active_q && $stable(addr_q)
	) else $error("Enables sampled during internal burst");

	a_global_write: assert property (
		ce_in && !pins_in.all_lanes_write_n |=> wr_lanes_q == SSIC_LANES_ALL
	) else $error("Global write did not select every lane");

	a_lane_gate: assert property (
		ce_in && pins_in.all_lanes_write_n && pins_in.lane_write_gate_n
			|=> wr_lanes_q == SSIC_LANES_NONE
	) else $error("Lane written without byte write gate");

	a_wb_ack: assert property (
		ce_in && wb_hit ##1 ce_in |=> !wb_ack_out
	) else $error("Bus acknowledge held longer than one cycle");

	a_lane_select: assert property (
		ce_in && pins_in.all_lanes_write_n && !pins_in.lane_write_gate_n
			|=> wr_lanes_q == ~$past(pins_in.lane_select_n)
	) else $error("Byte write gate did not pass the lane selects");

	a_write_no_valid: assert property (
		ce_in && wr_lanes_q != SSIC_LANES_NONE |=> !rd_valid_out
	) else $error("Read valid raised on a write cycle");

	a_read_valid: assert property (
		ce_in && active_q && wr_lanes_q == SSIC_LANES_NONE |=> rd_valid_out
	) else $error("Read cycle gave no valid data");

	a_both_strobes: assert property (
		ce_in && !pins_in.cpu_load_strobe_n && !pins_in.ctrl_load_strobe_n
			&& selected |=> active_q && addr_q == $past(addr_in)
	) else $error("Both strobes low did not load the address");

	a_third_absent: assert property (
		ce_in && load && !third_present_q && !pins_in.select_primary_n
			&& pins_in.select_second_high |=> active_q
	) else $error("Absent third enable still deselected the chip");

	a_ctrl_write: assert property (
		ce_in && wb_ack_out && wb_req_in.cyc && wb_req_in.stb
			&& wb_req_in.we && wb_req_in.sel[0]
			&& wb_req_in.adr == SSIC_REG_CTRL
			|=> third_present_q == $past(wb_req_in.dat[SSIC_CTRL_THIRD])
	) else $error("Control write did not land on the acknowledge edge");

	a_ce_freeze: assert property (
		!ce_in |=> $stable(active_q) && $stable(addr_q) && $stable(cnt_q)
			&& $stable(wb_ack_out) && $stable(rd_valid_out)
	) else $error("State moved while the clock enable was low");

	a_strap_follow: assert property (
		ce_in && strap_sync_q == strap_last_q
			|=> linear_q == !$past(strap_last_q)
	) else $error("Burst order did not follow the settled strap");

	a_wb_answer: assert property (
		ce_in && wb_hit |=> wb_ack_out
	) else $error("Bus request was not acknowledged");

	a_deselect_hold: assert property (
		ce_in && load && !selected |=> $stable(addr_q)
	) else $error("Deselect load changed the captured address");

	a_linear_pos: assert property (
		linear_q |-> SSIC_BURST_W'(pos - cnt_q) == start_q
	) else $error("Linear burst position out of sequence");

	a_interleave_pos: assert property (
		!linear_q |-> (pos ^ cnt_q) == start_q
	) else $error("Interleaved burst position out of sequence");

	a_primary_deselect: assert property (
		ce_in && load && pins_in.select_primary_n |=> !active_q
	) else $error("Load with primary enable high left chip active");

	a_second_deselect: assert property (
		ce_in && load && !pins_in.select_second_high |=> !active_q
	) else $error("Load with second enable low left chip active");

	a_third_deselect: assert property (
		ce_in && load && third_present_q && pins_in.select_third_n
			|=> !active_q
	) else $error("Load with third enable high left chip active");
endmodule : ssic_capture
`default_nettype wire

/* File: dv/ssic_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module ssic_partner #(
	parameter int unsigned ADDR_W = 8
) (
	input  wire logic                            clk_in,
	output var  ssic_pkg::ssic_ctrl_t            pins_out,
	output var  logic [ADDR_W-1:0]               addr_out,
	output var  logic [ssic_pkg::SSIC_DATA_W-1:0] data_out
);
	import ssic_pkg::*;
	// Strobes and writes off, chip deselected
	localparam ssic_ctrl_t IDLE = ssic_ctrl_t'(12'hFFD);
	initial begin
		pins_out = IDLE;
		addr_out = '0;
		data_out = '0;
	end
	// One bus cycle, address valid with its strobe
	task automatic drive(input ssic_ctrl_t p, input logic [ADDR_W-1:0] a,
		input logic [SSIC_DATA_W-1:0] d);
		@(posedge clk_in);
		pins_out <= p;
		addr_out <= a;
		data_out <= d;
	endtask : drive
	// Released lines flip so a stale value matches only on every second idle cycle
	task automatic idle(input int n);
		repeat (n) begin
			@(posedge clk_in);
			pins_out <= IDLE;
			addr_out <= ~addr_out;
			data_out <= ~data_out;
		end
	endtask : idle
endmodule : ssic_partner
`default_nettype wire

/* File: dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import ssic_pkg::*;
	typedef struct packed {
		logic [4:0] s;
		logic [2:0] e;
		logic [1:0] a;
		logic       act;
		logic [1:0] pos;
	} ssic_row_t;
	logic                   clk_in = 1'b0;
	logic                   reset_n_in = 1'b0;
	logic                   strap = 1'b1;
	logic                   ce = 1'b1;
	ssic_wb_req_t           wb_req = '0;
	ssic_ctrl_t             pins;
	logic [7:0]             addr;
	logic [SSIC_DATA_W-1:0] wdat;
	logic [SSIC_DATA_W-1:0] rdat;
	logic                   rval;
	logic                   ack;
	logic [31:0]            wdo;
	logic [31:0]            q;
	int                     miscompares = 0;
	int                     tests_run = 0;
	ssic_row_t              rows [7];
	localparam logic [35:0] M = {9'h000, 9'h1FF, 9'h000, 9'h1FF};
	localparam logic [35:0] D1 = 36'h123456789;
	localparam logic [35:0] D2 = 36'hFEDCBA987;
	always #4 clk_in = ~clk_in;

	ssic_capture #(.ADDR_W(8)) ssic_capture_i (.clk_in(clk_in),
		.reset_n_in(reset_n_in), .ce_in(ce), .pins_in(pins),
		.addr_in(addr), .wr_data_in(wdat), .mode_strap_in(strap),
		.rd_data_out(rdat), .rd_valid_out(rval), .wb_req_in(wb_req),
		.wb_dat_out(wdo), .wb_ack_out(ack));
	ssic_partner #(.ADDR_W(8)) ssic_partner_i (.clk_in(clk_in),
		.pins_out(pins), .addr_out(addr), .data_out(wdat));

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : summarize
	task automatic chk(input string n, input logic [35:0] s, e);
		tests_run++;
		if (s !== e) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", n, e, s);
		end
	endtask : chk
	// Held until ack is sampled, then one idle cycle
	task automatic wb(input logic we, input logic [3:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk_in);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: a, dat: d};
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = wdo;
		wb_req <= '0;
		if (n >= 20) begin
			miscompares++;
			summarize();
		end
	endtask : wb
	task automatic rst(input logic s);
		@(posedge clk_in);
		reset_n_in <= 1'b0;
		strap <= s;
		repeat (20) @(posedge clk_in);
		reset_n_in <= 1'b1;
	endtask : rst
	task automatic ld(input logic [4:0] s, input logic [2:0] e,
		input logic [7:0] a);
		ssic_partner_i.drive(ssic_ctrl_t'({s, 4'hF, e}), a, '0);
		ssic_partner_i.idle(1);
	endtask : ld
	task automatic wr(input logic [4:0] s, input logic [3:0] l,
		input logic [35:0] d);
		ld(5'h0F, 3'h2, 8'h20);
		ssic_partner_i.drive(ssic_ctrl_t'({s, l, 3'h5}), 8'h20, d);
		ssic_partner_i.idle(2);
	endtask : wr

	initial begin
		rows = '{{5'h0F, 3'h2, 2'h2, 1'b1, 2'h2}, {5'h0F, 3'h6, 2'h1, 1'b1, 2'h2},
			{5'h17, 3'h0, 2'h3, 1'b0, 2'h0}, {5'h17, 3'h2, 2'h3, 1'b1, 2'h3},
			{5'h17, 3'h3, 2'h1, 1'b0, 2'h0}, {5'h07, 3'h2, 2'h1, 1'b1, 2'h1},
			{5'h17, 3'h6, 2'h0, 1'b0, 2'h0}};
		@(negedge clk_in);
		chk("reset rd", {rval, ack}, 0);
		rst(1'b1);
		wb(1'b0, SSIC_REG_CTRL, 0);
		chk("ctrl reset", q, 1);
		wb(1'b0, 4'hC, 32'hFFFF);
		chk("unmapped", q, 0);
		$display("done reset");
		foreach (rows[i]) begin
			ld(rows[i].s, rows[i].e, {6'h05, rows[i].a});
			wb(1'b0, SSIC_REG_STATUS, 0);
			chk("active", q[0], rows[i].act);
			if (rows[i].act) chk("pos", q[3:2], rows[i].pos);
		end
		// Pin-absent variant: third enable no longer deselects
		wb(1'b1, SSIC_REG_CTRL, 0);
		ld(5'h17, 3'h3, 8'h41);
		wb(1'b0, SSIC_REG_STATUS, 0);
		chk("third absent", q[0], 1);
		wb(1'b1, SSIC_REG_CTRL, 1);
		$display("done table");
		for (int k = 0; k < 2; k++) begin
			if (k == 1) rst(1'b0);
			ld(5'h0F, 3'h2, 8'h13);
			ssic_partner_i.drive(ssic_ctrl_t'({5'h1B, 4'hF, 3'h5}), '0, '0);
			ssic_partner_i.idle(3);
			wb(1'b0, SSIC_REG_STATUS, 0);
			chk("linear", q[1], k);
			chk("step", q[3:2], k ? 2'h0 : 2'h2);
			wb(1'b0, SSIC_REG_ADDR, 0);
			chk("burst addr", q, k ? 32'h10 : 32'h12);
		end
		$display("done burst");
		wr(5'h1D, 4'hF, D1);
		wr(5'h1E, 4'hA, D2);
		wr(5'h1F, 4'h0, ~D2);
		ld(5'h0F, 3'h2, 8'h20);
		@(posedge clk_in);
		@(negedge clk_in);
		chk("rd valid", rval, 1);
		chk("rd data", rdat, (D2 & M) | (D1 & ~M));
		$display("done lanes");
		// Clock enable low: a selected load must leave no trace
		ld(5'h17, 3'h3, 8'h20);
		@(posedge clk_in);
		ce <= 1'b0;
		ld(5'h0F, 3'h2, 8'h21);
		ce <= 1'b1;
		wb(1'b0, SSIC_REG_STATUS, 0);
		chk("frozen load", q[0], 0);
		chk("rd idle", rval, 0);
		wb(1'b0, SSIC_REG_ADDR, 0);
		chk("frozen addr", q, 32'h20);
		$display("done enable");
		summarize();
	end
endmodule : testbench
`default_nettype wire
